// [common/cbd_pkg.sv]
// cbd_pkg: constants, carrier types and helpers for the bit, compare,
// branch and call decoder of a small 4-bit core.
// assumes 9-bit program words, an 11-bit program counter (4-bit page,
// 7-bit low part) and a 4-bit data RAM addressed by an external pointer.
package cbd_pkg;

    localparam int PAGE_W      = 4;
    localparam int LOW_W       = 7;
    localparam int DP_W        = 6;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;

    typedef logic [8:0] cbd_word_t;
    typedef logic [3:0] cbd_nib_t;

    typedef struct packed {
        logic [PAGE_W-1:0] page;
        logic [LOW_W-1:0]  low;
    } cbd_pc_t;

    // machine context saved when an interrupt is taken
    typedef struct packed {
        logic [DP_W-1:0] dp;
        logic            carry;
        logic            nop_mode;
    } cbd_ctx_t;

    // one-word opcodes (bit ops carry j in the two low bits)
    localparam cbd_word_t OP_BIT_SET    = 9'h05c;
    localparam cbd_word_t OP_BIT_CLR    = 9'h04c;
    localparam cbd_word_t OP_BIT_ZSKIP  = 9'h020;
    localparam cbd_word_t OP_ACC_MEMEQ  = 9'h026;
    localparam cbd_word_t OP_IRET       = 9'h046;
    localparam cbd_word_t OP_RET        = 9'h044;
    localparam cbd_word_t OP_RET_SKIP   = 9'h045;
    localparam cbd_word_t OP_MASK_OFF   = 9'h004;
    localparam cbd_word_t OP_UNMASK     = 9'h005;
    localparam cbd_word_t OP_EXT_TEST   = 9'h08f;
    // first words of two-word instructions (page in low nibble where given)
    localparam cbd_word_t OP_ACC_IMMEQ  = 9'h025;
    localparam cbd_word_t OP_FAR_JUMP   = 9'h030;
    localparam cbd_word_t OP_JUMP_IDX   = 9'h001;
    localparam cbd_word_t OP_FJUMP_IDX  = 9'h010;
    localparam cbd_word_t OP_FAR_CALL   = 9'h070;
    localparam cbd_word_t OP_FCALL_IDX  = 9'h050;
    // two top bits of a word that carries a 7-bit address
    localparam logic [1:0] TAG_JUMP     = 2'h3;
    localparam logic [1:0] TAG_CALL     = 2'h2;

    localparam logic [PAGE_W-1:0] CALL_PAGE = 4'h2;
    localparam cbd_pc_t PC_RESET    = 11'h000;
    // interrupt entry point; plain default, set by the core integration
    localparam cbd_pc_t IRQ_VECTOR  = 11'h080;

    typedef enum logic [1:0] {
        ST_EXEC     = 2'h0,
        ST_WORD2    = 2'h1,
        ST_SKIP2    = 2'h3,
        ST_RET_WAIT = 2'h2
    } cbd_state_t;

    typedef enum logic [2:0] {
        SK_NONE, SK_BIT_ZERO, SK_ACC_MEM, SK_ACC_IMM, SK_EXT_FLAG
    } cbd_skip_kind_t;

    function automatic logic cbd_two_word(input cbd_word_t w);
        return (w == OP_ACC_IMMEQ) || (w[8:4] == OP_FAR_JUMP[8:4]) ||
               (w == OP_JUMP_IDX) || (w == OP_FJUMP_IDX) ||
               (w[8:4] == OP_FAR_CALL[8:4]) || (w == OP_FCALL_IDX);
    endfunction

    function automatic cbd_nib_t cbd_bit_mask(input logic [1:0] j);
        return cbd_nib_t'(4'h1 << j);
    endfunction

    function automatic cbd_pc_t cbd_pc_inc(input cbd_pc_t pc);
        return cbd_pc_t'(pc + 11'h001);
    endfunction

endpackage

// [verilog/cbd_skip_eval.sv]
// cbd_skip_eval: evaluates the skip condition of a compare or test word.
// purely combinational; the caller registers the result.
`timescale 1ns/1ps
module cbd_skip_eval import cbd_pkg::*; (
    input  cbd_skip_kind_t kind,
    input  logic [1:0]     bit_sel,
    input  cbd_nib_t       imm,
    input  cbd_nib_t       acc,
    input  cbd_nib_t       ram_rdata,
    input  logic           ext_flag,
    output logic           hit
);
    always_comb begin
        case (kind)
            SK_BIT_ZERO: hit = ~ram_rdata[bit_sel];
            SK_ACC_MEM:  hit = (acc == ram_rdata);
            SK_ACC_IMM:  hit = (acc == imm);
            SK_EXT_FLAG: hit = ext_flag;
            default:     hit = 1'b0;
        endcase
    end
endmodule // cbd_skip_eval

// [verilog/cbd_decode.sv]
// cbd_decode: decode and execute of bit, compare, branch, call, return and
// interrupt-control words of a 4-bit core; owns pc, return stack, skip state.
// assumes rom returns the word at pc_r in the same cycle (instr_valid marks it)
// and ram_rdata is the nibble at the external data pointer.
`timescale 1ns/1ps
module cbd_decode import cbd_pkg::*; (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           instr_valid,
    input  wire cbd_word_t      instr,
    input  wire cbd_nib_t       acc,
    input  wire cbd_nib_t       ram_rdata,
    input  wire logic           ext_irq_event,
    input  wire logic           irq_take,
    input  wire cbd_ctx_t       ctx_now,
    output cbd_pc_t             pc_r,
    output logic [SP_W-1:0]     sp_r,
    output logic                ram_we_r,
    output cbd_nib_t            ram_wdata_r,
    output logic                irq_enable_r,
    output logic                ext_flag_r,
    output logic                skip_r,
    output logic                ctx_restore_r,
    output cbd_ctx_t            ctx_out_r
);
    cbd_state_t     state_r, state_nxt;
    cbd_pc_t        pc_nxt;
    logic [SP_W-1:0] sp_nxt;
    cbd_pc_t        stack_r [STACK_DEPTH];
    cbd_pc_t        stack_nxt [STACK_DEPTH];
    cbd_word_t      first_r, first_nxt;
    logic           skip_nxt, ram_we_nxt, irq_enable_flag_nxt, ext_nxt, restore_nxt;
    cbd_nib_t       ram_wdata_nxt;
    cbd_ctx_t       ctx_out_nxt, saved_ctx_r, saved_ctx_nxt;
    logic           saved_skip_r, saved_skip_nxt;
    cbd_skip_kind_t skip_kind;
    logic           skip_hit;
    logic           push_en;
    cbd_pc_t        push_val;
    logic [SP_W-1:0] sp_dec;

    assign sp_dec = sp_r - SP_W'(1);

    cbd_skip_eval u_skip (
        .kind      (skip_kind),
        .bit_sel   (instr[1:0]),
        .imm       (instr[3:0]),
        .acc       (acc),
        .ram_rdata (ram_rdata),
        .ext_flag  (ext_flag_r),
        .hit       (skip_hit)
    );

    always_comb begin
        state_nxt      = state_r;
        pc_nxt         = pc_r;
        sp_nxt         = sp_r;
        first_nxt      = first_r;
        skip_nxt       = skip_r;
        ram_we_nxt     = 1'b0;
        ram_wdata_nxt  = ram_wdata_r;
        irq_enable_flag_nxt       = irq_enable_r;
        ext_nxt        = ext_flag_r;
        restore_nxt    = 1'b0;
        ctx_out_nxt    = ctx_out_r;
        saved_ctx_nxt  = saved_ctx_r;
        saved_skip_nxt = saved_skip_r;
        skip_kind      = SK_NONE;
        push_en        = 1'b0;
        push_val       = cbd_pc_inc(pc_r);
        if (irq_take && state_r == ST_EXEC) begin
            // the word at pc_r is not executed; it is resumed on return
            push_en        = 1'b1;
            push_val       = pc_r;
            pc_nxt         = IRQ_VECTOR;
            irq_enable_flag_nxt       = 1'b0;
            saved_ctx_nxt  = ctx_now;
            saved_skip_nxt = skip_r;
            skip_nxt       = 1'b0;
        end else begin
            case (state_r)
                ST_EXEC: begin
                    if (instr_valid) begin
                        pc_nxt = cbd_pc_inc(pc_r);
                        if (skip_r) begin
                            skip_nxt = 1'b0;
                            if (cbd_two_word(instr)) begin
                                state_nxt = ST_SKIP2;
                            end
                        end else if (cbd_two_word(instr)) begin
                            first_nxt = instr;
                            state_nxt = ST_WORD2;
                        end else if (instr[8:7] == TAG_JUMP) begin
                            pc_nxt.low = instr[6:0];
                        end else if (instr[8:7] == TAG_CALL) begin
                            push_en     = 1'b1;
                            pc_nxt.page = CALL_PAGE;
                            pc_nxt.low  = instr[6:0];
                        end else if (instr[8:2] == OP_BIT_SET[8:2]) begin
                            ram_we_nxt    = 1'b1;
                            ram_wdata_nxt = ram_rdata | cbd_bit_mask(instr[1:0]);
                        end else if (instr[8:2] == OP_BIT_CLR[8:2]) begin
                            ram_we_nxt    = 1'b1;
                            ram_wdata_nxt = ram_rdata & ~cbd_bit_mask(instr[1:0]);
                        end else if (instr[8:2] == OP_BIT_ZSKIP[8:2]) begin
                            skip_kind = SK_BIT_ZERO;
                        end else if (instr == OP_ACC_MEMEQ) begin
                            skip_kind = SK_ACC_MEM;
                        end else if (instr == OP_EXT_TEST) begin
                            skip_kind = SK_EXT_FLAG;
                            ext_nxt   = 1'b0;
                        end else if (instr == OP_IRET) begin
                            pc_nxt      = stack_r[sp_dec];
                            sp_nxt      = sp_dec;
                            restore_nxt = 1'b1;
                            ctx_out_nxt = saved_ctx_r;
                            skip_nxt    = saved_skip_r;
                        end else if (instr == OP_RET || instr == OP_RET_SKIP) begin
                            pc_nxt    = stack_r[sp_dec];
                            sp_nxt    = sp_dec;
                            state_nxt = ST_RET_WAIT;
                            skip_nxt  = (instr == OP_RET_SKIP);
                        end else if (instr == OP_MASK_OFF) begin
                            irq_enable_flag_nxt = 1'b0;
                        end else if (instr == OP_UNMASK) begin
                            irq_enable_flag_nxt = 1'b1;
                        end
                        if (skip_hit) begin
                            skip_nxt = 1'b1;
                        end
                    end
                end
                ST_WORD2: begin
                    if (instr_valid) begin
                        pc_nxt    = cbd_pc_inc(pc_r);
                        state_nxt = ST_EXEC;
                        if (first_r == OP_ACC_IMMEQ) begin
                            skip_kind = SK_ACC_IMM;
                            skip_nxt  = skip_hit;
                        end else if (first_r[8:4] == OP_FAR_JUMP[8:4]) begin
                            pc_nxt = {first_r[3:0], instr[6:0]};
                        end else if (first_r == OP_JUMP_IDX) begin
                            pc_nxt.low = {instr[6:4], acc};
                        end else if (first_r == OP_FJUMP_IDX) begin
                            pc_nxt = {instr[3:0], instr[6:4], acc};
                        end else if (first_r[8:4] == OP_FAR_CALL[8:4]) begin
                            push_en = 1'b1;
                            pc_nxt  = {first_r[3:0], instr[6:0]};
                        end else if (first_r == OP_FCALL_IDX) begin
                            push_en = 1'b1;
                            pc_nxt  = {instr[3:0], instr[6:4], acc};
                        end
                    end
                end
                ST_SKIP2: begin
                    if (instr_valid) begin
                        pc_nxt    = cbd_pc_inc(pc_r);
                        state_nxt = ST_EXEC;
                    end
                end
                ST_RET_WAIT: begin
                    // second cycle of a return or return-with-skip: the fetched word is ignored
                    state_nxt = ST_EXEC;
                end
                default: begin
                    state_nxt = ST_EXEC;
                end
            endcase
        end
        if (push_en) begin
            sp_nxt = sp_r + SP_W'(1);
        end
        // a new external event wins over a same-cycle clear
        if (ext_irq_event) begin
            ext_nxt = 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_nxt[i] = stack_r[i];
        end
        // overflow wraps and overwrites the oldest entry; software must not nest deeper
        if (push_en) begin
            stack_nxt[sp_r] = push_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= ST_EXEC;
            pc_r         <= PC_RESET;
            sp_r         <= '0;
            first_r      <= '0;
            skip_r       <= 1'b0;
            ram_we_r     <= 1'b0;
            ram_wdata_r  <= '0;
            irq_enable_r <= 1'b0;
            ext_flag_r   <= 1'b0;
            ctx_restore_r <= 1'b0;
            ctx_out_r    <= '0;
            saved_ctx_r  <= '0;
            saved_skip_r <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= PC_RESET;
            end
        end else begin
            state_r      <= state_nxt;
            pc_r         <= pc_nxt;
            sp_r         <= sp_nxt;
            first_r      <= first_nxt;
            skip_r       <= skip_nxt;
            ram_we_r     <= ram_we_nxt;
            ram_wdata_r  <= ram_wdata_nxt;
            irq_enable_r <= irq_enable_flag_nxt;
            ext_flag_r   <= ext_nxt;
            ctx_restore_r <= restore_nxt;
            ctx_out_r    <= ctx_out_nxt;
            saved_ctx_r  <= saved_ctx_nxt;
            saved_skip_r <= saved_skip_nxt;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= stack_nxt[i];
            end
        end
    end

    // helper terms for the checks below
    logic exec1;
    logic sel_bit;
    logic [PAGE_W-1:0] page_now;
    assign exec1    = (state_r == ST_EXEC) && instr_valid && !skip_r && !irq_take;
    assign sel_bit  = ram_rdata[instr[1:0]];
    assign page_now = pc_r.page;

    a_bit_set_val: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr[8:2] == OP_BIT_SET[8:2] |=> ram_we_r &&
        ram_wdata_r[$past(instr[1:0])] && ram_wdata_r[3] == ($past(instr[1:0]) == 2'h3 ||
        $past(ram_rdata[3])))
        else $error("bit set result wrong");
    a_bit_clr_val: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr[8:2] == OP_BIT_CLR[8:2] |=> ram_we_r && !ram_wdata_r[$past(instr[1:0])])
        else $error("bit clear result wrong");
    a_zero_skip: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr[8:2] == OP_BIT_ZSKIP[8:2] |=> skip_r == !$past(sel_bit))
        else $error("bit zero skip wrong");
    a_mem_eq_skip: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr == OP_ACC_MEMEQ |=> skip_r == ($past(acc) == $past(ram_rdata)))
        else $error("acc mem compare skip wrong");
    a_local_jump: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr[8:7] == TAG_JUMP |=> page_now == $past(page_now) &&
        pc_r.low == $past(instr[6:0]))
        else $error("local jump target wrong");
    a_call_two: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr[8:7] == TAG_CALL |=> page_now == CALL_PAGE &&
        sp_r == $past(sp_r) + SP_W'(1) && state_r == ST_EXEC)
        else $error("page two call wrong");
    a_ret_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr == OP_RET |=> state_r == ST_RET_WAIT ##1 state_r == ST_EXEC)
        else $error("plain return not two cycles");
    a_ext_clear: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr == OP_EXT_TEST && ext_flag_r && !ext_irq_event |=> skip_r && !ext_flag_r)
        else $error("external flag test wrong");
    a_mask_off: assert property (@(posedge clk) disable iff (!rst_n)
        exec1 && instr == OP_MASK_OFF |=> !irq_enable_r)
        else $error("interrupt enable not cleared");
    a_skip_noop: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == ST_EXEC && instr_valid && skip_r && !irq_take |=>
        $stable(sp_r) && !ram_we_r && $stable(irq_enable_r) && !skip_r)
        else $error("skipped word had an effect");
endmodule // cbd_decode

// [bench/cbd_rom_ram_model.sv]
// cbd_rom_ram_model: program rom and one data ram nibble facing the decoder.
// assumes the data pointer stays still, so one nibble stands for the addressed word.
`timescale 1ns/1ps
module cbd_rom_ram_model import cbd_pkg::*; (
    input  wire logic      clk,
    input  wire cbd_pc_t   pc,
    input  wire logic      ram_we,
    input  wire cbd_nib_t  ram_wdata,
    output logic           instr_valid,
    output cbd_word_t      instr,
    output cbd_nib_t       ram_rdata
);
    cbd_word_t rom [0:2047];
    cbd_nib_t  ram_r;
    // set by the bench to stall a fetch for a cycle
    logic      hold = 1'b0;

    // rom answers in the same cycle, as the decoder expects
    assign instr_valid = !hold;
    assign instr       = rom[pc];
    assign ram_rdata   = ram_r;

    // the write lands one edge later, so a reader right after a write sees old data
    always @(posedge clk) begin
        if (ram_we) begin
            ram_r <= ram_wdata;
        end
    end
endmodule // cbd_rom_ram_model

// [bench/cpu_bit_compare_branch_call_decode_test.sv]
// testbench for the decoder: one task per scenario, self-checking.
// assumes the rom/ram model answers combinationally on pc_r.
`timescale 1ns/1ps
module cpu_bit_compare_branch_call_decode_test import cbd_pkg::*;;
    logic            clk;
    logic            rst_n;
    logic            instr_valid;
    cbd_word_t       instr;
    cbd_nib_t        acc;
    cbd_nib_t        ram_rdata;
    logic            ext_irq_event;
    logic            irq_take;
    cbd_ctx_t        ctx_now;
    cbd_pc_t         pc_r;
    logic [SP_W-1:0] sp_r;
    logic            ram_we_r;
    cbd_nib_t        ram_wdata_r;
    logic            irq_enable_r;
    logic            ext_flag_r;
    logic            skip_r;
    logic            ctx_restore_r;
    cbd_ctx_t        ctx_out_r;
    int              n_fail;
    int              checks;
    int              cyc;

    cbd_decode dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .acc(acc), .ram_rdata(ram_rdata), .ext_irq_event(ext_irq_event),
        .irq_take(irq_take), .ctx_now(ctx_now), .pc_r(pc_r), .sp_r(sp_r),
        .ram_we_r(ram_we_r), .ram_wdata_r(ram_wdata_r), .irq_enable_r(irq_enable_r),
        .ext_flag_r(ext_flag_r), .skip_r(skip_r), .ctx_restore_r(ctx_restore_r),
        .ctx_out_r(ctx_out_r));

    cbd_rom_ram_model m (.clk(clk), .pc(pc_r), .ram_we(ram_we_r), .ram_wdata(ram_wdata_r),
        .instr_valid(instr_valid), .instr(instr), .ram_rdata(ram_rdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // returns at the edge before the first active one; rom is refilled with a harmless word
    // only once the decoder sits in reset, so no fetch can race the refill
    task automatic rst(input int n);
        @(posedge clk);
        rst_n <= 1'b0;
        ext_irq_event <= 1'b0;
        irq_take <= 1'b0;
        m.hold <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 2048; i++) m.rom[i] = OP_MASK_OFF;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_bits();
        cbd_nib_t v;
        for (int k = 0; k < 8; k++) begin
            rst(1);
            m.ram_r <= 4'h6;
            m.rom[0] = (k < 4 ? OP_BIT_SET : OP_BIT_CLR) | cbd_word_t'(k[1:0]);
            v = (k < 4) ? (4'h6 | (4'h1 << k[1:0])) : (4'h6 & ~(4'h1 << k[1:0]));
            go(1);
            chk(11'(ram_we_r), 11'h1, "ram write");
            chk(11'(ram_wdata_r), 11'(v), "ram data");
        end
    endtask

    // a far jump to 0x2b3 follows the test word; skipping it passes both its words
    task automatic skip_case(input cbd_word_t w1, input cbd_word_t w2, input int k,
                             input cbd_nib_t a, input cbd_nib_t r, input logic f,
                             input logic s);
        rst(1);
        acc <= a;
        m.ram_r <= r;
        ext_irq_event <= f;
        m.rom[1] = w1;
        m.rom[2] = w2;
        m.rom[1 + k] = OP_FAR_JUMP | 9'h005;
        m.rom[2 + k] = 9'h1b3;
        @(posedge clk);
        ext_irq_event <= 1'b0;
        go(k + 2);
        chk(pc_r, s ? 11'(3 + k) : 11'h2b3, "skip pc");
        chk(11'(ext_flag_r), 11'h0, "ext flag");
    endtask

    task automatic t_skip();
        for (int j = 0; j < 4; j++) begin
            skip_case(OP_BIT_ZSKIP | cbd_word_t'(j), '0, 1, 4'h0, ~(4'h1 << j), 0, 1);
            skip_case(OP_BIT_ZSKIP | cbd_word_t'(j), '0, 1, 4'h0, 4'h1 << j, 0, 0);
        end
        skip_case(OP_ACC_MEMEQ, '0, 1, 4'h9, 4'h9, 0, 1);
        skip_case(OP_ACC_MEMEQ, '0, 1, 4'h9, 4'h8, 0, 0);
        skip_case(OP_ACC_IMMEQ, 9'h0bf, 2, 4'hf, 4'h0, 0, 1);
        skip_case(OP_ACC_IMMEQ, 9'h0b0, 2, 4'h1, 4'h0, 0, 0);
        skip_case(OP_EXT_TEST, '0, 1, 4'h0, 4'h0, 1, 1);
        skip_case(OP_EXT_TEST, '0, 1, 4'h0, 4'h0, 0, 0);
    endtask

    // first hop to page 9, address 0x10, so that a kept page is visible
    task automatic br_case(input cbd_word_t w1, input cbd_word_t w2, input int k,
                           input cbd_nib_t a, input cbd_pc_t exp);
        rst(1);
        acc <= a;
        m.rom[0] = OP_FAR_JUMP | 9'h009;
        m.rom[1] = 9'h190;
        m.rom[11'h490] = w1;
        m.rom[11'h491] = w2;
        go(2 + k);
        chk(pc_r, exp, "branch pc");
    endtask

    task automatic t_branch();
        br_case(9'h1a5, '0, 1, 4'h0, 11'h4a5);
        br_case(OP_JUMP_IDX, 9'h1d7, 2, 4'hc, {4'h9, 3'h5, 4'hc});
        br_case(OP_FAR_JUMP | 9'h00f, 9'h1ab, 2, 4'h0, {4'hf, 7'h2b});
        br_case(OP_FAR_JUMP, 9'h1ab, 2, 4'h0, {4'h0, 7'h2b});
        br_case(OP_FJUMP_IDX, 9'h1ef, 2, 4'h3, {4'hf, 3'h6, 4'h3});
    endtask

    // a held fetch between the two words of a far jump must not be decoded
    task automatic t_stall();
        rst(1);
        m.rom[0] = OP_FAR_JUMP | 9'h003;
        m.rom[1] = 9'h185;
        @(posedge clk);
        m.hold <= 1'b1;
        @(posedge clk);
        m.hold <= 1'b0;
        go(0);
        chk(pc_r, 11'h001, "pc held while stalled");
        go(1);
        chk(pc_r, 11'h185, "far jump after stall");
    endtask

    task automatic t_call();
        rst(1);
        acc <= 4'h7;
        m.rom[0] = 9'h111;
        m.rom[11'h111] = OP_RET;
        m.rom[1] = OP_FAR_CALL | 9'h006;
        m.rom[2] = 9'h122;
        m.rom[11'h322] = OP_RET_SKIP;
        m.rom[3] = OP_FCALL_IDX;
        m.rom[4] = 9'h1ff;
        m.rom[5] = OP_FCALL_IDX;
        m.rom[6] = 9'h15c;
        m.rom[11'h657] = OP_IRET;
        m.rom[7] = OP_UNMASK;
        go(1);
        chk(pc_r, 11'h111, "page two call");
        chk(11'(sp_r), 11'h1, "sp push");
        go(1);
        chk(pc_r, 11'h001, "return");
        chk(11'(sp_r), 11'h0, "sp pop");
        go(1);
        chk(pc_r, 11'h001, "return second cycle");
        go(2);
        chk(pc_r, 11'h322, "far call");
        chk(11'(sp_r), 11'h1, "sp push");
        go(1);
        chk(pc_r, 11'h003, "return skip");
        go(3);
        chk(pc_r, 11'h005, "skipped at return");
        go(2);
        chk(pc_r, 11'h657, "far indexed call");
        chk(11'(sp_r), 11'h1, "sp push");
        go(1);
        chk(pc_r, 11'h007, "interrupt return");
        go(1);
        chk(pc_r, 11'h008, "one cycle return");
        chk(11'(irq_enable_r), 11'h1, "unmask");
        go(1);
        chk(11'(irq_enable_r), 11'h0, "mask off");
    endtask

    // the interrupted word follows a taken compare, so a skip is pending when saved
    task automatic t_irq();
        rst(1);
        acc <= 4'h3;
        m.ram_r <= 4'h3;
        m.rom[0] = OP_ACC_MEMEQ;
        m.rom[IRQ_VECTOR] = OP_IRET;
        @(posedge clk);
        irq_take <= 1'b1;
        ctx_now <= 8'h5a;
        @(posedge clk);
        irq_take <= 1'b0;
        ctx_now <= 8'ha5;
        go(0);
        chk(pc_r, IRQ_VECTOR, "vector");
        go(1);
        chk(pc_r, 11'h001, "back to interrupted word");
        chk(11'(ctx_restore_r), 11'h1, "restore pulse");
        chk(11'(ctx_out_r), 11'h05a, "restored context");
        chk(11'(skip_r), 11'h1, "restored skip");
    endtask

    // no scenario here needs more than a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            $display("ERROR %0t run too long", $time);
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        acc = 4'h0;
        ext_irq_event = 1'b0;
        irq_take = 1'b0;
        ctx_now = '0;
        // sixteen reset edges in all, counting the two inside the task
        rst(14);
        t_bits();
        t_skip();
        t_branch();
        t_stall();
        t_call();
        t_irq();
        complete_run();
    end
endmodule // cpu_bit_compare_branch_call_decode_test
